// ### rtl/mmdec_router.sv
// module: memory map router for cpu program/data, dma and usb dma masters
`timescale 1ns/1ps
module mmdec_router #(
  parameter int MASTERS = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // remap select control: software write and reset instruction
  input wire logic remap_we_i,
  input wire logic remap_wdata_i,
  input wire logic soft_reset_i,
  // memory requests: 0 program, 1 data, 2 dma, 3 usb dma
  input mmdec_pkg::mmdec_req_s mem_req_i [MASTERS],
  // io request, one per cycle
  input wire logic io_valid_i,
  input wire logic io_write_i,
  input wire logic io_from_dma_i,
  input wire logic [15:0] io_addr_i,
  // memory routing results, registered
  output mmdec_pkg::mmdec_route_s mem_route_o [MASTERS],
  output logic [MASTERS-1:0] mem_grant_o,
  output logic [MASTERS-1:0] mem_stall_o,
  output logic [MASTERS-1:0] ext_select_o [5],
  // io routing results, registered
  output logic io_grant_o,
  output logic [4:0] io_window_o,
  output logic io_reserved_o,
  output logic io_read_zero_o,
  // remap select state
  output logic rom_remap_select_o
);
  logic rom_remap_select;
  logic next_remap;
  mmdec_pkg::mmdec_route_s route [MASTERS];
  logic [MASTERS-1:0] want_single;
  logic [MASTERS-1:0] want_dual;
  logic [MASTERS-1:0] grant;
  logic [MASTERS-1:0] stall;
  logic [MASTERS-1:0] ext_sel [5];
  logic [4:0] io_window;
  logic io_hit;
  logic io_take;
  localparam int SINGLE_W = mmdec_pkg::SINGLE_BLOCKS;

  // remap select: hardware reset clears it, soft reset instruction leaves it
  assign next_remap = remap_we_i ? remap_wdata_i : rom_remap_select;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rom_remap_select <= mmdec_pkg::RESET_REMAP;
    end else begin
      rom_remap_select <= next_remap;
    end
  end

  // one decoder per master; ports 2 and up are dma masters
  genvar m;
  generate
    for (m = 0; m < MASTERS; m++) begin : g_dec
      mmdec_addr_decode #(
        .IS_DMA(m >= 2)
      ) u_dec (
        .addr_i(mem_req_i[m].addr),
        .remap_i(rom_remap_select),
        .route_o(route[m])
      );
      assign want_single[m] = mem_req_i[m].valid && (route[m].target == mmdec_pkg::MMDEC_T_SINGLE);
      assign want_dual[m] = mem_req_i[m].valid && (route[m].target == mmdec_pkg::MMDEC_T_DUAL);
      // external selects, one per chip-select space
      assign ext_sel[0][m] = mem_req_i[m].valid && (route[m].target == mmdec_pkg::MMDEC_T_EXT0);
      assign ext_sel[1][m] = mem_req_i[m].valid && (route[m].target == mmdec_pkg::MMDEC_T_EXT2);
      assign ext_sel[2][m] = mem_req_i[m].valid && (route[m].target == mmdec_pkg::MMDEC_T_EXT3);
      assign ext_sel[3][m] = mem_req_i[m].valid && (route[m].target == mmdec_pkg::MMDEC_T_EXT4);
      assign ext_sel[4][m] = mem_req_i[m].valid && (route[m].target == mmdec_pkg::MMDEC_T_EXT5);
    end
  endgenerate

  // fixed priority per block: lower master index wins, later ones wait a cycle.
  // dual ram takes two per block; more than two on one block also waits.
  always_comb begin
    logic [SINGLE_W-1:0] single_busy;
    logic [1:0] dual_used [mmdec_pkg::DUAL_BLOCKS];
    single_busy = '0;
    for (int b = 0; b < mmdec_pkg::DUAL_BLOCKS; b++) begin
      dual_used[b] = 2'b00;
    end
    grant = '0;
    stall = '0;
    for (int i = 0; i < MASTERS; i++) begin
      if (want_single[i]) begin
        if (single_busy[route[i].block]) begin
          stall[i] = 1'b1;
        end else begin
          single_busy[route[i].block] = 1'b1;
          grant[i] = 1'b1;
        end
      end else if (want_dual[i]) begin
        if (dual_used[route[i].block[2:0]] == 2'd2) begin
          stall[i] = 1'b1;
        end else begin
          dual_used[route[i].block[2:0]] = dual_used[route[i].block[2:0]] + 2'd1;
          grant[i] = 1'b1;
        end
      end else if (mem_req_i[i].valid && route[i].target != mmdec_pkg::MMDEC_T_NONE) begin
        grant[i] = 1'b1;
      end
    end
  end

  // io space: own decoder, reserved words answered at once
  mmdec_io_decode u_io (
    .addr_i(io_addr_i),
    .from_dma_i(io_from_dma_i),
    .window_o(io_window),
    .hit_o(io_hit)
  );
  assign io_take = io_valid_i;

  // registered results; stalled masters simply re-present next cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_grant_o <= '0;
      mem_stall_o <= '0;
      io_grant_o <= 1'b0;
      io_window_o <= mmdec_pkg::IO_NONE;
      io_reserved_o <= 1'b0;
      io_read_zero_o <= 1'b0;
      rom_remap_select_o <= mmdec_pkg::RESET_REMAP;
      for (int i = 0; i < MASTERS; i++) begin
        mem_route_o[i] <= '{target: mmdec_pkg::MMDEC_T_NONE, block: 5'h00};
      end
      for (int s = 0; s < 5; s++) begin
        ext_select_o[s] <= '0;
      end
    end else begin
      mem_grant_o <= grant;
      mem_stall_o <= stall;
      io_grant_o <= io_take;
      io_window_o <= io_hit ? io_window : mmdec_pkg::IO_NONE;
      io_reserved_o <= io_take && !io_hit;
      io_read_zero_o <= io_take && !io_hit && !io_write_i;
      rom_remap_select_o <= next_remap;
      for (int i = 0; i < MASTERS; i++) begin
        mem_route_o[i] <= route[i];
      end
      for (int s = 0; s < 5; s++) begin
        ext_select_o[s] <= ext_sel[s] & grant;
      end
    end
  end

  // soft reset pulse is seen but must not disturb the remap bit
  a_soft_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    (soft_reset_i && !remap_we_i) |=> (rom_remap_select == $past(rom_remap_select)))
    else $error("remap select changed on soft reset");

  a_reset_clear: assert property (@(posedge clk_i)
    $fell(rst_i) |-> (rom_remap_select == 1'b0))
    else $error("remap select not clear after reset");

  sequence s_single_clash;
    want_single[0] && want_single[1] && (route[0].block == route[1].block);
  endsequence
  a_single_serial: assert property (@(posedge clk_i) disable iff (rst_i)
    s_single_clash |=> (mem_grant_o[0] && !mem_grant_o[1] && mem_stall_o[1]))
    else $error("single block conflict not serialised");

  a_single_one: assert property (@(posedge clk_i) disable iff (rst_i)
    (grant[0] && grant[3] && want_single[0] && want_single[3]) |-> (route[0].block != route[3].block))
    else $error("two grants on one single block");

  a_dual_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    (want_dual[0] && want_dual[1]) |-> (grant[0] && grant[1]))
    else $error("dual block refused a pair");

  a_rom_cpu_only: assert property (@(posedge clk_i) disable iff (rst_i)
    (route[2].target != mmdec_pkg::MMDEC_T_ROM) && (route[3].target != mmdec_pkg::MMDEC_T_ROM))
    else $error("dma routed to rom");

  a_rom_remap: assert property (@(posedge clk_i) disable iff (rst_i)
    (mem_req_i[0].addr[31:17] == 15'h007F && rom_remap_select) |-> (route[0].target == mmdec_pkg::MMDEC_T_EXT5))
    else $error("remapped rom range not on select five");

  a_io_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
    (io_valid_i && !io_hit && !io_write_i) |=> (io_grant_o && io_read_zero_o && io_window_o == mmdec_pkg::IO_NONE))
    else $error("reserved io read did not complete with zero");

  a_mapped_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (mem_req_i[1].addr < 32'h000000C0) |-> (route[1].target == mmdec_pkg::MMDEC_T_MAPPED))
    else $error("mapped register area not decoded");
endmodule : mmdec_router

// ### inc/mmdec_pkg.sv
// package: memory map constants, targets and request carriers for the decoder
package mmdec_pkg;
  // cpu byte map
  localparam logic [23:0] CPU_DUAL_BASE = 24'h000000;
  localparam logic [23:0] CPU_DUAL_LAST = 24'h00FFFF;
  localparam logic [23:0] CPU_MAPPED_LAST = 24'h0000BF;
  localparam logic [23:0] CPU_SINGLE_BASE = 24'h010000;
  localparam logic [23:0] CPU_SINGLE_LAST = 24'h04FFFF;
  localparam logic [23:0] CPU_EXT0_BASE = 24'h050000;
  localparam logic [23:0] CPU_EXT2_BASE = 24'h800000;
  localparam logic [23:0] CPU_EXT3_BASE = 24'hC00000;
  localparam logic [23:0] CPU_EXT4_BASE = 24'hE00000;
  localparam logic [23:0] CPU_EXT5_BASE = 24'hF00000;
  localparam logic [23:0] CPU_ROM_BASE = 24'hFE0000;
  // dma byte map
  localparam logic [31:0] DMA_DUAL_BASE = 32'h00010000;
  localparam logic [31:0] DMA_DUAL_LAST = 32'h0001FFFF;
  localparam logic [31:0] DMA_SINGLE_BASE = 32'h00090000;
  localparam logic [31:0] DMA_SINGLE_LAST = 32'h000CFFFF;
  // block geometry: 8k byte ram blocks, 32k byte rom blocks
  localparam int BLOCK_LSB = 13;
  localparam int DUAL_BLOCKS = 8;
  localparam int SINGLE_BLOCKS = 32;
  localparam int ROM_BLOCK_LSB = 15;
  // io word map, one entry per peripheral window
  localparam int IO_WINDOWS = 24;
  localparam logic [15:0] IO_BASE [IO_WINDOWS] = '{
    16'h0000, 16'h0C00, 16'h0D00, 16'h0E00, 16'h0F00, 16'h1000, 16'h1800, 16'h1840,
    16'h1880, 16'h1900, 16'h1A00, 16'h1B00, 16'h1C00, 16'h2800, 16'h2A00, 16'h2B00,
    16'h2E00, 16'h3000, 16'h3400, 16'h3A00, 16'h3B00, 16'h4000, 16'h6000, 16'h7000};
  localparam logic [15:0] IO_LAST [IO_WINDOWS] = '{
    16'h0004, 16'h0C7F, 16'h0D7F, 16'h0E7F, 16'h0F7F, 16'h10DD, 16'h181F, 16'h185F,
    16'h189F, 16'h197F, 16'h1A6C, 16'h1B1F, 16'h1CFF, 16'h2840, 16'h2A40, 16'h2B40,
    16'h2E81, 16'h300F, 16'h3749, 16'h3A7F, 16'h3B7F, 16'h407F, 16'h60FF, 16'h70FF};
  // windows that dma may reach (bit n = window n); usb window handled apart
  // memory port, i2c, uart, three i2s, multichannel spi, two cards, serial port and its dma, adc
  localparam logic [IO_WINDOWS-1:0] IO_DMA_OK = 24'hFCEC20;
  localparam logic [15:0] IO_USB_BASE = 16'h8000;
  localparam logic [4:0] IO_NONE = 5'h1F;
  localparam logic [4:0] IO_USB = 5'h18;
  localparam logic RESET_REMAP = 1'b0;

  typedef enum logic [3:0] {
    MMDEC_T_NONE, MMDEC_T_MAPPED, MMDEC_T_DUAL, MMDEC_T_SINGLE, MMDEC_T_ROM,
    MMDEC_T_EXT0, MMDEC_T_EXT2, MMDEC_T_EXT3, MMDEC_T_EXT4, MMDEC_T_EXT5
  } mmdec_target_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
  } mmdec_req_s;

  typedef struct packed {
    mmdec_target_e target;
    logic [4:0] block;
  } mmdec_route_s;
endpackage : mmdec_pkg

// ### rtl/mmdec_addr_decode.sv
// module: combinational byte address decoder for one master port
`timescale 1ns/1ps
module mmdec_addr_decode #(
  parameter bit IS_DMA = 1'b0
) (
  // request
  input wire logic [31:0] addr_i,
  input wire logic remap_i,
  // route
  output mmdec_pkg::mmdec_route_s route_o
);
  logic [23:0] a;
  logic in_dual_dma;
  logic in_single_dma;
  logic [31:0] dual_off;
  logic [31:0] single_off;

  // dma view is the cpu view shifted to its own base
  assign a = addr_i[23:0];
  assign in_dual_dma = (addr_i >= mmdec_pkg::DMA_DUAL_BASE) && (addr_i <= mmdec_pkg::DMA_DUAL_LAST);
  assign in_single_dma = (addr_i >= mmdec_pkg::DMA_SINGLE_BASE) && (addr_i <= mmdec_pkg::DMA_SINGLE_LAST);
  assign dual_off = addr_i - mmdec_pkg::DMA_DUAL_BASE;
  assign single_off = addr_i - mmdec_pkg::DMA_SINGLE_BASE;

  // priority chain over the 16m byte unified map
  always_comb begin
    route_o.target = mmdec_pkg::MMDEC_T_NONE;
    route_o.block = 5'h00;
    if (IS_DMA) begin
      // dma never reaches rom; the bottom of its dual range reaches the register area
      if (in_dual_dma) begin
        route_o.target = (dual_off[15:0] <= 16'h00BF) ? mmdec_pkg::MMDEC_T_MAPPED : mmdec_pkg::MMDEC_T_DUAL;
        route_o.block = {2'b00, dual_off[15:13]};
      end else if (in_single_dma) begin
        route_o.target = mmdec_pkg::MMDEC_T_SINGLE;
        route_o.block = single_off[17:13];
      end
    end else if (addr_i[31:24] != 8'h00) begin
      route_o.target = mmdec_pkg::MMDEC_T_NONE;
    end else if (a <= mmdec_pkg::CPU_MAPPED_LAST) begin
      route_o.target = mmdec_pkg::MMDEC_T_MAPPED;
    end else if (a <= mmdec_pkg::CPU_DUAL_LAST) begin
      route_o.target = mmdec_pkg::MMDEC_T_DUAL;
      route_o.block = {2'b00, a[15:13]};
    end else if (a <= mmdec_pkg::CPU_SINGLE_LAST) begin
      route_o.target = mmdec_pkg::MMDEC_T_SINGLE;
      route_o.block = 5'((a - mmdec_pkg::CPU_SINGLE_BASE) >> mmdec_pkg::BLOCK_LSB);
    end else if (a < mmdec_pkg::CPU_EXT2_BASE) begin
      route_o.target = mmdec_pkg::MMDEC_T_EXT0;
    end else if (a < mmdec_pkg::CPU_EXT3_BASE) begin
      route_o.target = mmdec_pkg::MMDEC_T_EXT2;
    end else if (a < mmdec_pkg::CPU_EXT4_BASE) begin
      route_o.target = mmdec_pkg::MMDEC_T_EXT3;
    end else if (a < mmdec_pkg::CPU_EXT5_BASE) begin
      route_o.target = mmdec_pkg::MMDEC_T_EXT4;
    end else if (a < mmdec_pkg::CPU_ROM_BASE || remap_i) begin
      route_o.target = mmdec_pkg::MMDEC_T_EXT5;
    end else begin
      route_o.target = mmdec_pkg::MMDEC_T_ROM;
      route_o.block = {3'b000, a[16:15]};
    end
  end
endmodule : mmdec_addr_decode

// ### rtl/mmdec_io_decode.sv
// module: io space word address decoder into peripheral windows
`timescale 1ns/1ps
module mmdec_io_decode (
  // request
  input wire logic [15:0] addr_i,
  input wire logic from_dma_i,
  // result
  output logic [4:0] window_o,
  output logic hit_o
);
  logic [mmdec_pkg::IO_WINDOWS-1:0] in_win;
  logic usb_hit;

  // one comparator pair per window
  genvar g;
  generate
    for (g = 0; g < mmdec_pkg::IO_WINDOWS; g++) begin : g_win
      assign in_win[g] = (addr_i >= mmdec_pkg::IO_BASE[g]) && (addr_i <= mmdec_pkg::IO_LAST[g]) &&
                         (!from_dma_i || mmdec_pkg::IO_DMA_OK[g]);
    end
  endgenerate
  assign usb_hit = addr_i >= mmdec_pkg::IO_USB_BASE;

  // windows never overlap, so the encoder is one-hot safe
  always_comb begin
    window_o = mmdec_pkg::IO_NONE;
    hit_o = 1'b0;
    if (usb_hit) begin
      window_o = mmdec_pkg::IO_USB;
      hit_o = 1'b1;
    end
    for (int i = 0; i < mmdec_pkg::IO_WINDOWS; i++) begin
      if (in_win[i]) begin
        window_o = 5'(i);
        hit_o = 1'b1;
      end
    end
  end
endmodule : mmdec_io_decode

// ### testbench/mmdec_master_model.sv
// model: cpu and dma masters that present requests and retry when stalled
`timescale 1ns/1ps
module mmdec_master_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bench load
  input wire logic load_i,
  input mmdec_pkg::mmdec_req_s load_req_i [4],
  // router side
  input wire logic [3:0] stall_i,
  output mmdec_pkg::mmdec_req_s req_o [4]
);
  mmdec_pkg::mmdec_req_s keep [4];
  logic [3:0] sent;
  // a request stands one cycle; an idle address is scrambled so stale values never match
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int m = 0; m < 4; m++) begin
        req_o[m] <= '0;
        keep[m] <= '0;
      end
      sent <= 4'h0;
    end else begin
      for (int m = 0; m < 4; m++) begin
        if (load_i) begin
          req_o[m] <= load_req_i[m]; // bench never loads the boot block while booting
          sent[m] <= 1'b0;
        end else if (req_o[m].valid) begin
          keep[m] <= req_o[m];
          req_o[m].valid <= 1'b0;
          req_o[m].addr <= ~req_o[m].addr;
          sent[m] <= 1'b1;
        end else if (sent[m]) begin
          sent[m] <= 1'b0;
          if (stall_i[m]) begin
            req_o[m] <= keep[m]; // loser presents the same request again
          end
        end else begin
          req_o[m].addr <= ~req_o[m].addr;
        end
      end
    end
  end
endmodule : mmdec_master_model

// ### testbench/dsp_memory_map_decoder_bench.sv
// bench: self-checking scenarios for the memory map router
`timescale 1ns/1ps
module dsp_memory_map_decoder_bench;
  logic clk, rst, rwe, rwd, srst, iov, iow, iod, load;
  logic [15:0] ioa;
  mmdec_pkg::mmdec_req_s lreq [4];
  mmdec_pkg::mmdec_req_s mreq [4];
  mmdec_pkg::mmdec_route_s route [4];
  logic [3:0] grant, stall;
  logic [3:0] ext [5];
  logic io_grant, io_res, io_rz, remap;
  logic [4:0] io_win;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;

  mmdec_router #(.MASTERS(4)) dut_u (.clk_i(clk), .rst_i(rst), .remap_we_i(rwe), .remap_wdata_i(rwd),
    .soft_reset_i(srst), .mem_req_i(mreq), .io_valid_i(iov), .io_write_i(iow), .io_from_dma_i(iod),
    .io_addr_i(ioa), .mem_route_o(route), .mem_grant_o(grant), .mem_stall_o(stall), .ext_select_o(ext),
    .io_grant_o(io_grant), .io_window_o(io_win), .io_reserved_o(io_res), .io_read_zero_o(io_rz),
    .rom_remap_select_o(remap));
  mmdec_master_model master_u (.clk_i(clk), .rst_i(rst), .load_i(load), .load_req_i(lreq),
    .stall_i(stall), .req_o(mreq));

  // clock and hang guard; the ceiling is far above the few hundred cycles needed
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (bad_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic cmp_route(input string what, input mmdec_pkg::mmdec_target_e t, input int b,
      input mmdec_pkg::mmdec_route_s got);
    mmdec_pkg::mmdec_route_s e;
    e.target = t;
    e.block = 5'(b);
    cmp(what, 32'(e), 32'(got));
  endtask : cmp_route
  // request helpers; every master idles unless set
  task automatic clr();
    for (int m = 0; m < 4; m++) lreq[m] = '0;
  endtask : clr
  task automatic set_req(input int m, input logic wr, input logic [31:0] a);
    lreq[m] = '{valid: 1'b1, write: wr, addr: a};
  endtask : set_req
  task automatic issue();
    @(posedge clk) load <= 1'b1;
    @(posedge clk) load <= 1'b0;
    @(posedge clk) #1;
  endtask : issue
  task automatic wait_retry();
    @(posedge clk);
    @(posedge clk) #1;
  endtask : wait_retry
  task automatic io_go(input logic dma, input logic wr, input logic [15:0] a);
    @(posedge clk) begin
      iov <= 1'b1;
      iow <= wr;
      iod <= dma;
      ioa <= a;
    end
    @(posedge clk) iov <= 1'b0;
    #1;
  endtask : io_go

  // dual ram blocks, dma view, mapped area edge, third master on one block
  task automatic t_dual();
    for (int b = 0; b < 8; b++) begin
      clr();
      set_req(1, 1'b0, b * 32'h2000 + 32'h1FFF);
      set_req(2, 1'b1, 32'h00010000 + b * 32'h2000 + 32'h100);
      issue();
      cmp_route("cpu dual", mmdec_pkg::MMDEC_T_DUAL, b, route[1]);
      cmp_route("dma dual", mmdec_pkg::MMDEC_T_DUAL, b, route[2]);
      cmp("dual pair grant", 32'h6, 32'(grant));
    end
    clr();
    set_req(0, 1'b0, 32'h000000BF);
    set_req(1, 1'b1, 32'h000000C0);
    issue();
    cmp_route("mapped top", mmdec_pkg::MMDEC_T_MAPPED, 0, route[0]);
    cmp_route("dual above map", mmdec_pkg::MMDEC_T_DUAL, 0, route[1]);
    clr();
    set_req(0, 1'b0, 32'h2000);
    set_req(1, 1'b1, 32'h2010);
    set_req(2, 1'b1, 32'h00012020);
    issue();
    cmp("dual two granted", 32'h3, 32'(grant));
    cmp("dual third stalls", 32'h4, 32'(stall));
    wait_retry();
    cmp("dual retry grant", 32'h4, 32'(grant));
  endtask : t_dual

  // every single ram block from cpu and usb dma, then a same-block conflict
  task automatic t_single();
    for (int b = 0; b < 32; b++) begin
      clr();
      set_req(0, 1'b0, 32'h011000 + b * 32'h2000); // upper half keeps off the boot area
      set_req(3, 1'b1, 32'h00091000 + (31 - b) * 32'h2000);
      issue();
      cmp_route("cpu single", mmdec_pkg::MMDEC_T_SINGLE, b, route[0]);
      cmp_route("usb single", mmdec_pkg::MMDEC_T_SINGLE, 31 - b, route[3]);
      cmp("single split grant", 32'h9, 32'(grant));
    end
    clr();
    set_req(0, 1'b0, 32'h01A000);
    set_req(1, 1'b1, 32'h01A004);
    set_req(2, 1'b0, 32'h00090000);
    issue();
    cmp_route("dma single", mmdec_pkg::MMDEC_T_SINGLE, 0, route[2]);
    cmp("single winner", 32'h5, 32'(grant));
    cmp("single loser", 32'h2, 32'(stall));
    wait_retry();
    cmp("single retry", 32'h2, 32'(grant));
    cmp_route("retry route", mmdec_pkg::MMDEC_T_SINGLE, 5, route[1]);
  endtask : t_single

  // external spaces by chip select, and cpu bits above 16m
  task automatic t_ext();
    logic [31:0] base [5] = '{32'h050000, 32'h800000, 32'hC00000, 32'hE00000, 32'hF00000};
    mmdec_pkg::mmdec_target_e tg [5] = '{mmdec_pkg::MMDEC_T_EXT0, mmdec_pkg::MMDEC_T_EXT2,
      mmdec_pkg::MMDEC_T_EXT3, mmdec_pkg::MMDEC_T_EXT4, mmdec_pkg::MMDEC_T_EXT5};
    for (int k = 0; k < 5; k++) begin
      clr();
      set_req(0, 1'b0, base[k]);
      issue();
      cmp("ext target", 32'(tg[k]), 32'(route[0].target));
      cmp("ext select", 32'h1, 32'(ext[k]));
    end
    clr();
    set_req(1, 1'b0, 32'h01000000);
    issue();
    cmp("beyond 16m", 32'(mmdec_pkg::MMDEC_T_NONE), 32'(route[1].target));
    cmp("beyond 16m grant", 32'h0, 32'(grant));
  endtask : t_ext

  // rom, remap select, soft and hard reset
  task automatic t_rom();
    clr();
    set_req(0, 1'b0, 32'hFE0000);
    set_req(1, 1'b0, 32'hFFFFFF);
    set_req(2, 1'b0, 32'h050E0000);
    issue();
    cmp_route("rom low", mmdec_pkg::MMDEC_T_ROM, 0, route[0]);
    cmp_route("rom high", mmdec_pkg::MMDEC_T_ROM, 3, route[1]);
    cmp("dma no rom", 32'h0, 32'(route[2].target == mmdec_pkg::MMDEC_T_ROM));
    @(posedge clk) begin
      rwe <= 1'b1;
      rwd <= 1'b1;
    end
    @(posedge clk) rwe <= 1'b0;
    clr();
    set_req(0, 1'b0, 32'hFE0000);
    issue();
    cmp("remap set", 32'h1, 32'(remap));
    cmp("remap to cs5", 32'(mmdec_pkg::MMDEC_T_EXT5), 32'(route[0].target));
    cmp("cs5 select", 32'h1, 32'(ext[4]));
    @(posedge clk) srst <= 1'b1;
    @(posedge clk) srst <= 1'b0;
    @(posedge clk) #1;
    cmp("soft reset keeps", 32'h1, 32'(remap));
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    #1;
    cmp("hard reset clears", 32'h0, 32'(remap));
    issue();
    cmp_route("rom back", mmdec_pkg::MMDEC_T_ROM, 0, route[0]);
  endtask : t_rom

  // io windows for cpu and dma, usb window, reserved words
  // stimulus assumes every peripheral is out of reset and clocked; no gating here
  task automatic t_io();
    for (int w = 0; w < mmdec_pkg::IO_WINDOWS; w++) begin
      io_go(1'b0, 1'b0, mmdec_pkg::IO_BASE[w]);
      cmp("cpu io window", 32'(w), 32'(io_win));
      cmp("cpu io grant", 32'h2, 32'({io_grant, io_res}));
      io_go(1'b1, 1'b1, mmdec_pkg::IO_LAST[w]);
      cmp("dma io window", mmdec_pkg::IO_DMA_OK[w] ? 32'(w) : 32'(mmdec_pkg::IO_NONE), 32'(io_win));
    end
    io_go(1'b1, 1'b0, 16'h8000);
    cmp("dma usb window", 32'(mmdec_pkg::IO_USB), 32'(io_win));
    io_go(1'b0, 1'b0, 16'hFFFF);
    cmp("cpu usb top", 32'(mmdec_pkg::IO_USB), 32'(io_win));
    // only these two probes check a reserved-word answer, to prove the no-stall answer
    io_go(1'b0, 1'b0, 16'h0005);
    cmp("reserved read", 32'h7, 32'({io_grant, io_res, io_rz}));
    io_go(1'b1, 1'b1, 16'h10DE);
    cmp("reserved write", 32'h6, 32'({io_grant, io_res, io_rz}));
  endtask : t_io

  // reset, values after reset, then the scenarios
  initial begin
    rst = 1'b1;
    {rwe, rwd, srst, iov, iow, iod, load} = 7'h00;
    ioa = 16'h0000;
    clr();
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    cmp("reset window", 32'(mmdec_pkg::IO_NONE), 32'(io_win));
    cmp("reset remap", 32'(mmdec_pkg::RESET_REMAP), 32'(remap));
    t_dual();
    t_single();
    t_ext();
    t_rom();
    t_io();
    finish_test();
  end
endmodule : dsp_memory_map_decoder_bench
